/* File: design/microsequencer_next_state.sv */
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "seq_map.svh"

module microsequencer_next_state #(
  parameter int STACK_ENTRIES = `STACK_ENTRIES_DEF
) (
  input  wire logic        aclk,           // system clock, 20 MHz
  input  wire logic        aresetn,        // synchronous reset, active low
  input  wire logic [7:0]  s_axi_awaddr,   // write address
  input  wire logic        s_axi_awvalid,  // write address valid
  output logic             s_axi_awready,  // write address ready
  input  wire logic [31:0] s_axi_wdata,    // write data
  input  wire logic [3:0]  s_axi_wstrb,    // write byte enables
  input  wire logic        s_axi_wvalid,   // write data valid
  output logic             s_axi_wready,   // write data ready
  output logic [1:0]       s_axi_bresp,    // write response
  output logic             s_axi_bvalid,   // write response valid
  input  wire logic        s_axi_bready,   // write response ready
  input  wire logic [7:0]  s_axi_araddr,   // read address
  input  wire logic        s_axi_arvalid,  // read address valid
  output logic             s_axi_arready,  // read address ready
  output logic [31:0]      s_axi_rdata,    // read data
  output logic [1:0]       s_axi_rresp,    // read response
  output logic             s_axi_rvalid,   // read data valid
  input  wire logic        s_axi_rready,   // read data ready
  input  wire logic [7:0]  seq_in,         // general-purpose branch inputs
  input  wire logic        master_clear_n, // master clear pin, active low
  output logic [15:0]      user_out,       // user outputs of current word
  output logic             user_out_oe,    // high while user outputs driven
  output logic             supervisor_mode // short clear pulse was seen
);

  logic [7:0]                 in_meta;
  logic [7:0]                 in_sync;
  logic                       clr_meta;
  logic                       clr_sync;
  logic                       phase;
  logic                       run;
  seq_pkg::microword_type     pipe;
  seq_pkg::microword_type     sel_word;
  logic [1:0]                 sel_lane;
  logic [7:0]                 cur_addr;
  logic [1:0]                 cur_lane;
  logic [7:0]                 loop_count;
  logic                       zero_flag;
  logic [7:0]                 stack_mem [0:STACK_ENTRIES-1];
  logic [3:0]                 depth;
  logic [7:0]                 tos;
  seq_pkg::clear_state_type   clear_state;
  logic [1:0]                 low_edges;
  logic                       hold_second;
  logic                       clear_now;
  logic                       word0_now;
  logic                       seq_step;
  logic [7:0]                 next_addr;
  logic [7:0]                 fetch_addr;
  logic [7:0]                 fetched_addr;
  logic [`WORD_WIDTH-1:0]     lane_q [0:`LANE_COUNT-1];
  logic [15:0]                branch_inputs;
  logic [`TERM_LANES-1:0]     term_hit;
  logic                       cond1;
  logic                       cond2;
  logic                       cond3;
  logic                       push_en;
  logic                       pop_en;
  logic [7:0]                 push_val;
  logic                       cnt_load;
  logic                       cnt_dec;
  logic [7:0]                 cnt_val;
  logic [31:0]                stage_lo;
  logic [3:0]                 stage_hi;
  logic                       store_we;
  logic [3:0]                 store_lane;
  logic [7:0]                 store_addr;
  logic [7:0]                 aw_addr;
  logic [31:0]                w_data;
  logic [3:0]                 w_strb;
  logic                       do_write;
  logic [31:0]                rd_value;
  logic [31:0]                ctrl_merged;
  logic [31:0]                hi_merged;

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // a term with its enable clear never fires, so blank memory selects lane 0
  function automatic logic pt_hit(input logic [`WORD_WIDTH-1:0] t,
                                  input logic [15:0]             v);
    return t[`PT_ENABLE_BIT] && ((v & t[`PT_ONES]) == t[`PT_ONES])
           && ((v & t[`PT_ZEROS]) == 16'h0000);
  endfunction

  function automatic logic addr_known(input logic [7:0] a);
    return (a == `REG_CTRL) || (a == `REG_STATUS) || (a == `REG_STAGE_LO)
           || (a == `REG_STAGE_HI) || (a == `REG_STORE_CMD) || (a == `REG_TOP);
  endfunction

  // pins cross into the clock domain through two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_meta  <= 8'h00;
      in_sync  <= 8'h00;
      clr_meta <= 1'b1;
      clr_sync <= 1'b1;
    end else begin
      in_meta  <= seq_in;
      in_sync  <= in_meta;
      clr_meta <= master_clear_n;
      clr_sync <= clr_meta;
    end
  end

  // sequencer edge every second clock: fetch on phase 0, step on phase 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end

  assign zero_flag = (loop_count == 8'h00);
  assign tos = (depth == 4'h0) ? 8'h00 : stack_mem[depth - 4'h1];

  always_comb begin
    if (pipe.opcode_field == `OP_RETURN) begin
      next_addr = tos;
    end else if (pipe.opcode_field == `OP_OP_LOOP_NONZERO && !zero_flag) begin
      next_addr = pipe.data;
    end else begin
      next_addr = pipe.next_addr;
    end
  end

  assign fetch_addr = (clear_state == seq_pkg::rs_low) ? 8'h00 : next_addr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetched_addr <= 8'h00;
    end else if (!phase) begin
      fetched_addr <= fetch_addr;
    end
  end

  // four lanes of words, then twelve lanes of product terms
  for (genvar g = 0; g < `LANE_COUNT; g++) begin : g_lane
    localparam int DEPTH = (g == 0) ? `WORD_LOCATIONS : `MULTIWAY_LOCATIONS;
    localparam int AW    = (g == 0) ? 8 : 6;
    micro_store #(
      .WIDTH (`WORD_WIDTH),
      .DEPTH (DEPTH),
      .AW    (AW)
    ) u_store (
      .clk     (aclk),
      .wr_en   (store_we && (store_lane == 4'(g))),
      .wr_addr (store_addr[AW-1:0]),
      .wr_data ({stage_hi, stage_lo}),
      .rd_en   (!phase),
      .rd_addr (fetch_addr[AW-1:0]),
      .rd_data (lane_q[g])
    );
  end

  assign branch_inputs = {loop_count, in_sync};

  for (genvar t = 0; t < `TERM_LANES; t++) begin : g_term
    assign term_hit[t] = pt_hit(lane_q[`WORD_LANES + t], branch_inputs);
  end

  assign cond1 = |term_hit[0 +: `TERMS_PER_COND];
  assign cond2 = |term_hit[`TERMS_PER_COND +: `TERMS_PER_COND];
  assign cond3 = |term_hit[2*`TERMS_PER_COND +: `TERMS_PER_COND];

  always_comb begin
    if (fetched_addr < `MULTIWAY_BASE) begin
      sel_lane = 2'h0;
    end else if (cond3) begin
      sel_lane = 2'h3;
    end else if (cond2) begin
      sel_lane = 2'h2;
    end else if (cond1) begin
      sel_lane = 2'h1;
    end else begin
      sel_lane = 2'h0;
    end
  end

  assign sel_word = lane_q[sel_lane];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clear_state     <= seq_pkg::rs_run;
      low_edges       <= 2'h0;
      hold_second     <= 1'b0;
      supervisor_mode <= 1'b0;
    end else if (phase) begin
      case (clear_state)
        seq_pkg::rs_run: begin
          if (!clr_sync) begin
            clear_state <= seq_pkg::rs_low;
            low_edges   <= `CLEAR_SHORT_EDGES;
          end
        end
        seq_pkg::rs_low: begin
          if (!clr_sync) begin
            if (low_edges != `CLEAR_FULL_EDGES) begin
              low_edges <= low_edges + 2'h1;
            end
            if (low_edges == `CLEAR_ACT_EDGES) begin
              supervisor_mode <= 1'b0;
            end
          end else begin
            low_edges <= 2'h0;
            if (low_edges == `CLEAR_FULL_EDGES) begin
              clear_state <= seq_pkg::rs_hold;
              hold_second <= 1'b0;
            end else begin
              // two edges is undefined; sequencing simply resumes
              clear_state <= seq_pkg::rs_run;
              if (low_edges == `CLEAR_SHORT_EDGES) begin
                supervisor_mode <= 1'b1;
              end
            end
          end
        end
        seq_pkg::rs_hold: begin
          if (!clr_sync) begin
            clear_state <= seq_pkg::rs_low;
            low_edges   <= `CLEAR_SHORT_EDGES;
          end else if (!hold_second) begin
            hold_second <= 1'b1;
          end else begin
            clear_state <= seq_pkg::rs_run;
          end
        end
        default: begin
          clear_state <= seq_pkg::rs_run;
        end
      endcase
    end
  end

  assign clear_now = phase && !clr_sync && (clear_state == seq_pkg::rs_low)
                     && (low_edges == `CLEAR_ACT_EDGES);
  assign word0_now = phase && !clr_sync && (clear_state == seq_pkg::rs_low)
                     && (low_edges == `CLEAR_FULL_EDGES);
  // supervisor mode freezes sequencing until a full clear
  assign seq_step  = phase && clr_sync && run && !supervisor_mode
                     && ((clear_state == seq_pkg::rs_run)
                         || (clear_state == seq_pkg::rs_hold && hold_second));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pipe     <= '0;
      cur_addr <= 8'h00;
      cur_lane <= 2'h0;
    // word zero from fourth low edge
    end else if (word0_now) begin
      pipe     <= lane_q[0];
      cur_addr <= 8'h00;
      cur_lane <= 2'h0;
    end else if (seq_step) begin
      pipe     <= sel_word;
      cur_addr <= fetched_addr;
      cur_lane <= sel_lane;
    end
  end

  always_comb begin
    push_en  = 1'b0;
    pop_en   = 1'b0;
    push_val = pipe.data;
    cnt_load = 1'b0;
    cnt_dec  = 1'b0;
    cnt_val  = pipe.data;
    case (pipe.opcode_field)
      `OP_CALL:      push_en = 1'b1;
      `OP_RETURN:    pop_en = 1'b1;
      `OP_LOADC:     cnt_load = 1'b1;
      `OP_OP_LOOP_NONZERO:    cnt_dec = 1'b1;
      `OP_PUSHLOADC: begin
        push_en  = 1'b1;
        push_val = loop_count;
        cnt_load = 1'b1;
      end
      `OP_POPC: begin
        pop_en   = 1'b1;
        cnt_load = 1'b1;
        cnt_val  = tos;
      end
      `OP_PUSHI: begin
        push_en  = 1'b1;
        push_val = in_sync;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      depth <= 4'h0;
      for (int i = 0; i < STACK_ENTRIES; i++) begin
        stack_mem[i] <= 8'h00;
      end
    end else if (clear_now) begin
      depth <= 4'h0;
    end else if (seq_step && push_en) begin
      if (depth == 4'(STACK_ENTRIES)) begin
        stack_mem[STACK_ENTRIES-1] <= push_val;
      end else begin
        stack_mem[depth] <= push_val;
        depth            <= depth + 4'h1;
      end
    end else if (seq_step && pop_en && depth != 4'h0) begin
      depth <= depth - 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_count <= 8'h00;
    end else if (clear_now) begin
      loop_count <= 8'h00;
    end else if (seq_step && cnt_load) begin
      loop_count <= cnt_val;
    end else if (seq_step && cnt_dec && !zero_flag) begin
      loop_count <= loop_count - 8'h01;
    end
  end

  assign user_out    = pipe.user;
  assign user_out_oe = pipe.enable;

  // write channel: address and data taken independently, then one response
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_known(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // byte enables are merged first, then the field is picked out
  assign ctrl_merged = apply_strb({31'h0, run}, w_data, w_strb);
  assign hi_merged   = apply_strb({28'h0, stage_hi}, w_data, w_strb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run        <= 1'b0;
      stage_lo   <= 32'h0000_0000;
      stage_hi   <= 4'h0;
      store_we   <= 1'b0;
      store_lane <= 4'h0;
      store_addr <= 8'h00;
    end else begin
      store_we <= 1'b0;
      if (do_write) begin
        if (aw_addr == `REG_CTRL) begin
          run <= ctrl_merged[`CTRL_RUN_BIT];
        end else if (aw_addr == `REG_STAGE_LO) begin
          stage_lo <= apply_strb(stage_lo, w_data, w_strb);
        end else if (aw_addr == `REG_STAGE_HI) begin
          stage_hi <= hi_merged[`STAGE_HI_BITS];
        end else if (aw_addr == `REG_STORE_CMD) begin
          store_we   <= 1'b1;
          store_addr <= w_data[`CMD_ADDR];
          store_lane <= w_data[`CMD_LANE];
        end
      end
    end
  end

  always_comb begin
    if (s_axi_araddr == `REG_CTRL) begin
      rd_value = {31'h0, run};
    end else if (s_axi_araddr == `REG_STATUS) begin
      rd_value = {8'h00, cur_lane, supervisor_mode, zero_flag, depth, loop_count, cur_addr};
    end else if (s_axi_araddr == `REG_STAGE_LO) begin
      rd_value = stage_lo;
    end else if (s_axi_araddr == `REG_STAGE_HI) begin
      rd_value = {28'h0, stage_hi};
    end else if (s_axi_araddr == `REG_STORE_CMD) begin
      rd_value = {20'h0, store_lane, store_addr};
    end else if (s_axi_araddr == `REG_TOP) begin
      rd_value = {24'h0, tos};
    end else begin
      rd_value = 32'h0000_0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_value;
      s_axi_rresp   <= addr_known(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

/* File: design/seq_map.svh */
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH

// register byte offsets
`define REG_CTRL            8'h00
`define REG_STATUS          8'h04
`define REG_STAGE_LO        8'h08
`define REG_STAGE_HI        8'h0C
`define REG_STORE_CMD       8'h10
`define REG_TOP             8'h14

// register fields
`define CTRL_RUN_BIT        0
`define CMD_ADDR            7:0
`define CMD_LANE            11:8
`define STAGE_HI_BITS       3:0

// axi responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

// opcode encodings
`define OP_JUMP             3'h0
`define OP_CALL             3'h1
`define OP_RETURN           3'h2
`define OP_LOADC            3'h3
`define OP_OP_LOOP_NONZERO           3'h4
`define OP_PUSHLOADC        3'h5
`define OP_POPC             3'h6
`define OP_PUSHI            3'h7

// microcode organisation
`define MULTIWAY_BASE       8'hC0
`define WORD_LOCATIONS      256
`define MULTIWAY_LOCATIONS  64
`define WORD_LANES          4
`define TERM_LANES          12
`define TERMS_PER_COND      4
`define LANE_COUNT          16
`define WORD_WIDTH          36
`define STACK_ENTRIES_DEF   15

// product term layout inside a 36-bit lane word
`define PT_ONES             15:0
`define PT_ZEROS            31:16
`define PT_ENABLE_BIT       32

// master clear edge counts
`define CLEAR_SHORT_EDGES   2'h1
`define CLEAR_ACT_EDGES     2'h2
`define CLEAR_FULL_EDGES    2'h3

`endif

/* File: design/seq_pkg.sv */
`default_nettype none

package seq_pkg;

  typedef struct packed {
    logic [15:0] user;
    logic [7:0]  next_addr;
    logic [7:0]  data;
    logic [2:0]  opcode_field;
    logic        enable;
  } microword_type;

  typedef enum logic [1:0] {
    rs_run,
    rs_low,
    rs_hold
  } clear_state_type;

endpackage

`default_nettype wire

/* File: design/micro_store.sv */
`timescale 1ns/100ps
`default_nettype none

module micro_store #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic             clk,     // system clock
  input  wire logic             wr_en,   // write strobe
  input  wire logic [AW-1:0]    wr_addr, // write index
  input  wire logic [WIDTH-1:0] wr_data, // write word
  input  wire logic             rd_en,   // read strobe
  input  wire logic [AW-1:0]    rd_addr, // read index
  output logic      [WIDTH-1:0] rd_data  // registered read word
);

  logic [WIDTH-1:0] mem [0:DEPTH-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

`default_nettype wire

/* File: verification/microsequencer_next_state_props.sv */
`timescale 1ns/100ps
`default_nettype none

module seq_props (
  input wire logic        aclk,           // clock
  input wire logic        aresetn,        // reset, active low
  input wire logic        s_axi_awvalid,  // aw valid
  input wire logic        s_axi_awready,  // aw ready
  input wire logic        s_axi_wvalid,   // w valid
  input wire logic        s_axi_wready,   // w ready
  input wire logic        s_axi_bvalid,   // b valid
  input wire logic [7:0]  s_axi_araddr,   // read address
  input wire logic        s_axi_arvalid,  // ar valid
  input wire logic        s_axi_arready,  // ar ready
  input wire logic [31:0] s_axi_rdata,    // read data
  input wire logic [1:0]  s_axi_rresp,    // read response
  input wire logic        s_axi_rvalid,   // r valid
  input wire logic        master_clear_n, // clear pin
  input wire logic [15:0] user_out,       // user outputs
  input wire logic        user_out_oe     // output enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer not on time");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not on time");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while pending");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while pending");
  a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  a_tick_spacing: assert property (
    $changed({user_out, user_out_oe}) |=> $stable({user_out, user_out_oe}))
    else $error("word changed between ticks");
  a_clear_holds_word: assert property (
    !master_clear_n [*8] ##1 !master_clear_n [*8] |-> $stable({user_out, user_out_oe}))
    else $error("word moved during clear");
  a_release_holds: assert property (
    $rose(master_clear_n) |=> $stable({user_out, user_out_oe}) [*4])
    else $error("word moved right after clear");
endmodule

bind microsequencer_next_state seq_props seq_props_i (.*);

`default_nettype wire

/* File: verification/far_end.sv */
`timescale 1ns/100ps
`default_nettype none

module far_end (
  input  wire logic       aclk,          // clock
  output var logic [7:0]  seq_in,        // condition inputs
  output var logic        master_clear_n // clear pin
);
  initial begin
    seq_in = 8'h00;
    master_clear_n = 1'b1;
  end

  task automatic set_in(input logic [7:0] v);
    @(posedge aclk);
    seq_in <= v;
  endtask

  // low for three edges or more
  task automatic clear(input int ticks);
    @(posedge aclk);
    master_clear_n <= 1'b0;
    repeat (2 * (ticks < 3 ? 3 : ticks)) @(posedge aclk);
    master_clear_n <= 1'b1;
  endtask

  task automatic glitch();
    @(posedge aclk);
    master_clear_n <= 1'b0;
    repeat (2) @(posedge aclk);
    master_clear_n <= 1'b1;
  endtask
endmodule

`default_nettype wire

/* File: verification/test_microsequencer_next_state.sv */
`timescale 1ns/100ps
`default_nettype none
`include "seq_map.svh"

module test_microsequencer_next_state;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  logic [7:0]  seq_in;
  logic        master_clear_n, user_out_oe, supervisor_mode;
  logic [15:0] user_out;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          cnt, inp;
  int          stk[$];
  int          u[6] = '{1, 2, 4, 8, 16, 32};
  int          q[6] = '{1, 2, 0, 4, 5, 192};
  int          d[6] = '{5, 3, 0, 3, 0, 0};
  int          op[6] = '{3, 1, 2, 4, 7, 6};
  int          e[6] = '{1, 1, 1, 0, 1, 1};

  microsequencer_next_state microsequencer_next_state_i (.*);
  far_end far_end_i (.aclk(aclk), .seq_in(seq_in), .master_clear_n(master_clear_n));

  always #25 aclk = ~aclk;

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // hang guard, far above the several hundred cycles needed
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end while (s_axi_bready);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end while (s_axi_rready);
  endtask

  task automatic store(input logic [7:0] a, input logic [3:0] l, input logic [35:0] w);
    wr(`REG_STAGE_LO, w[31:0]);
    wr(`REG_STAGE_HI, {28'h0, w[35:32]});
    wr(`REG_STORE_CMD, {20'h0, l, a});
  endtask

  function automatic int pop();
    if (stk.size() == 0)
      return 0;
    return stk.pop_back();
  endfunction

  function automatic int sel(input int v);
    return v[0] ? 3 : v[1] ? 2 : v[2] ? 1 : 0;
  endfunction

  task automatic model(input int v);
    int pc;
    pc = 0;
    cnt = 0;
    stk = {};
    while (pc < 192) begin
      case (op[pc])
        1: stk.push_back(d[pc]);
        3: cnt = d[pc];
        6: cnt = pop();
        7: stk.push_back(v);
        default: ;
      endcase
      if (op[pc] == 2)
        pc = pop();
      else if (op[pc] == 4 && cnt != 0) begin
        cnt--;
        pc = d[pc];
      end else
        pc = q[pc];
    end
  endtask

  task automatic end_chk();
    int ln;
    model(inp);
    ln = sel(inp);
    rd_reg(`REG_STATUS, rd, rs);
    chk("status", {8'h0, 2'(ln), 1'b0, cnt == 0, 4'(stk.size()), 8'(cnt), 8'hC0},
        {8'h0, rd[23:0]});
    rd_reg(`REG_TOP, rd, rs);
    chk("top", 32'h0, rd);
    chk("out", {15'h0, 1'b1, 16'h0100 << ln}, {15'h0, user_out_oe, user_out});
  endtask

  initial begin
    void'($urandom(66));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_reg(`REG_STATUS, rd, rs);
    chk("status", 32'h0010_0000, rd);
    rd_reg(8'h40, rd, rs);
    chk("unmapped resp", 32'h2, {30'h0, rs});
    wr(8'h40, 32'h0);
    chk("unmapped write resp", 32'h2, {30'h0, rs});
    for (int i = 0; i < 6; i++)
      store(8'(i), 4'h0, {16'(u[i]), 8'(q[i]), 8'(d[i]), 3'(op[i]), 1'(e[i])});
    for (int k = 0; k < 4; k++)
      store(8'hC0, 4'(k), {16'h0100 << k, 8'hC0, 8'h00, 3'h0, 1'b1});
    // one enabled term per condition on seq_in bits 2, 1, 0
    for (int l = 4; l < 16; l++)
      store(8'hC0, 4'(l), (l % 4 != 0) ? 36'h0 : {4'h1, 16'h0, 16'(1 << (3 - l / 4))});
    inp = $urandom % 256;
    far_end_i.set_in(8'(inp));
    wr(`REG_CTRL, 32'h1);
    repeat (100) @(posedge aclk);
    end_chk();
    repeat (6) begin
      inp = $urandom % 256;
      far_end_i.set_in(8'(inp));
      repeat (12) @(posedge aclk);
      chk("out", {15'h0, 1'b1, 16'h0100 << sel(inp)}, {15'h0, user_out_oe, user_out});
    end
    far_end_i.glitch();
    far_end_i.set_in(8'(255 - inp));
    repeat (12) @(posedge aclk);
    chk("supervisor", 32'h1, {31'h0, supervisor_mode});
    chk("frozen out", {15'h0, 1'b1, 16'h0100 << sel(inp)},
        {15'h0, user_out_oe, user_out});
    inp = 255 - inp;
    fork
      far_end_i.clear(12);
      begin
        repeat (20) @(posedge aclk);
        chk("out", 32'h0001_0001, {15'h0, user_out_oe, user_out});
        rd_reg(`REG_STATUS, rd, rs);
        chk("status", 32'h0010_0000, {8'h0, rd[23:0]});
      end
    join
    repeat (100) @(posedge aclk);
    end_chk();
    test_done();
  end
endmodule

`default_nettype wire
